// File: sim/sct_ctl_properties.sv
`timescale 1ns/1ps

module sct_ctl_checker #(
    parameter int unsigned TICK_CYCLES = 25000
) (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        restart_entry,
    input wire logic        supply_ov,
    input wire logic        supply_uv,
    input wire logic [1:0]  sw_overcurrent,
    input wire logic [1:0]  sw_overtemp,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        sw_one_on,
    input wire logic        sw_two_on,
    input wire logic        supply_shutdown,
    input wire logic        timer_a_out,
    input wire logic        timer_b_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // switch and timer outputs come out of reset low
    a_reset_zero: assert property (disable iff (1'b0) !nrst |=>
        !sw_one_on && !sw_two_on && !timer_a_out && !timer_b_out)
        else $error("outputs not low after reset");
    // unused bits read as zero
    a_rsvd_zero: assert property (avs_read && !avs_waitrequest &&
        avs_address != 8'h7c |-> avs_readdata[31:7] == 25'h0 &&
        !avs_readdata[3]) else $error("unused bits read nonzero");
    a_sd_low_zero: assert property (avs_read && !avs_waitrequest &&
        avs_address == 8'h40 |-> avs_readdata[3:0] == 4'h0)
        else $error("shutdown low bits read nonzero");
    // supply shutdown holds the switches off
    a_sd_off: assert property (supply_shutdown &&
        $past(supply_shutdown) |-> !sw_one_on && !sw_two_on)
        else $error("switch on during supply shutdown");
    a_sd_cause: assert property ($rose(supply_shutdown) |->
        supply_ov || supply_uv) else $error("shutdown without fault");
    // a switch fault turns that switch off
    a_fault_one: assert property (sw_overcurrent[0] ||
        sw_overtemp[0] |-> ##2 !sw_one_on)
        else $error("switch one on after fault");
    a_fault_two: assert property (sw_overcurrent[1] ||
        sw_overtemp[1] |-> ##2 !sw_two_on)
        else $error("switch two on after fault");
    // restart entry clears the switch sources
    a_restart_off: assert property (restart_entry |-> ##2
        !sw_one_on && !sw_two_on) else $error("switch on after restart");
    // every access gets exactly one wait cycle
    a_one_wait: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest)
        else $error("wait cycle count wrong");
endmodule : sct_ctl_checker

bind sct_switch_timer_ctl sct_ctl_checker #(.TICK_CYCLES(TICK_CYCLES))
    sct_ctl_checker_i (.mclk(mclk), .nrst(nrst),
    .restart_entry(restart_entry), .supply_ov(supply_ov),
    .supply_uv(supply_uv), .sw_overcurrent(sw_overcurrent),
    .sw_overtemp(sw_overtemp), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sw_one_on(sw_one_on), .sw_two_on(sw_two_on),
    .supply_shutdown(supply_shutdown), .timer_a_out(timer_a_out),
    .timer_b_out(timer_b_out));

// File: sim/sct_load_model.sv
`timescale 1ns/1ps

module sct_load_model (
    input  wire logic        mclk,
    input  wire logic        clr,
    input  wire logic        sw_on,
    output logic      [15:0] on_cycles
);
    // counts the cycles in which the load is powered
    always_ff @(posedge mclk) begin
        if (clr) begin
            on_cycles <= 16'h0000;
        end else if (sw_on) begin
            on_cycles <= on_cycles + 16'h0001;
        end
    end
endmodule : sct_load_model

// File: sim/sct_switch_timer_ctl_test.sv
`timescale 1ns/1ps

module sct_switch_timer_ctl_test;
    logic        mclk, nrst, soft_reset, restart_entry, restart_active;
    logic        cyclic_sense_active, supply_ov, supply_uv, clr;
    logic        pulse_gen_a, pulse_gen_b, avs_read, avs_write;
    logic        avs_waitrequest, sw_one_on, sw_two_on, supply_shutdown;
    logic        timer_a_out, timer_b_out;
    logic [1:0]  sw_overcurrent, sw_overtemp;
    logic [3:0]  avs_byteenable;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [15:0] on_cycles;
    int          num_errors, checked;

    sct_switch_timer_ctl #(.TICK_CYCLES(5)) sct_switch_timer_ctl_i (
        .mclk(mclk), .nrst(nrst), .soft_reset(soft_reset),
        .restart_entry(restart_entry), .restart_active(restart_active),
        .cyclic_sense_active(cyclic_sense_active), .supply_ov(supply_ov),
        .supply_uv(supply_uv), .sw_overcurrent(sw_overcurrent),
        .sw_overtemp(sw_overtemp), .pulse_gen_a(pulse_gen_a),
        .pulse_gen_b(pulse_gen_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sw_one_on(sw_one_on), .sw_two_on(sw_two_on),
        .supply_shutdown(supply_shutdown), .timer_a_out(timer_a_out),
        .timer_b_out(timer_b_out));

    sct_load_model sct_load_model_i (.mclk(mclk), .clr(clr),
        .sw_on(sw_one_on), .on_cycles(on_cycles));

    // 250 MHz clock
    always #2 mclk = ~mclk;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // one bus transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            chk("waitrequest", 32'h0, 32'h1);
            end_sim();
        end else begin
            q = avs_readdata[7:0];
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk($sformatf("register %h", a), {24'h0, e}, {24'h0, q});
    endtask : rd

    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask : w

    task automatic sw(input logic e1, input logic e2);
        chk("sw_one_on", {31'h0, e1}, {31'h0, sw_one_on});
        chk("sw_two_on", {31'h0, e2}, {31'h0, sw_two_on});
    endtask : sw

    task automatic t_regs;
        rd(8'h34, 8'h00);
        rd(8'h40, 8'h00);
        rd(8'h50, 8'h00);
        rd(8'h44, 8'h00);
        wr(8'h34, 8'hee);
        rd(8'h34, 8'h66);
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h70);
        wr(8'h50, 8'hdd);
        rd(8'h50, 8'h55);
        $display("register test done");
    endtask : t_regs

    // every source code, pulse generators and timers as sources
    task automatic t_src;
        logic [7:0] e;
        for (int p = 0; p < 2; p++) begin
            @(posedge mclk);
            pulse_gen_a <= (p == 0);
            pulse_gen_b <= (p == 1);
            wr(8'h30, (p == 0) ? 8'h60 : 8'h00);
            wr(8'h34, (p == 0) ? 8'h00 : 8'h60);
            e = (p == 0) ? 8'h16 : 8'h2a;
            for (int c = 0; c < 8; c++) begin
                wr(8'h50, {1'b0, 3'(c), 1'b0, 3'(c)});
                w(3);
                sw(e[c], e[c]);
            end
            chk("timer_a_out", {31'h0, p == 0}, {31'h0, timer_a_out});
            chk("timer_b_out", {31'h0, p == 1}, {31'h0, timer_b_out});
            rd(8'h7c, (p == 0) ? 8'h01 : 8'h02);
        end
        $display("source test done");
    endtask : t_src

    task automatic meas(input logic [2:0] on, input logic [2:0] per,
                        input int win, input int e);
        wr(8'h34, {1'b0, on, 1'b0, per});
        w(20);
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (win) @(posedge mclk);
        @(negedge mclk);
        chk("on cycles", 32'(e), {16'h0, on_cycles});
    endtask : meas

    // tick is 5 cycles: on-times 1/3/10/100 ticks, periods 100..500
    task automatic t_timer;
        wr(8'h50, 8'h33);
        meas(3'h1, 3'h1, 2000, 10);
        meas(3'h2, 3'h1, 2000, 30);
        meas(3'h3, 3'h1, 2000, 100);
        meas(3'h4, 3'h1, 2000, 1000);
        meas(3'h1, 3'h0, 1000, 10);
        meas(3'h1, 3'h2, 5000, 10);
        $display("timer test done");
    endtask : t_timer

    task automatic t_supply;
        wr(8'h40, 8'h00);
        wr(8'h50, 8'h11);
        @(posedge mclk);
        supply_ov <= 1'b1;
        w(3);
        sw(1'b0, 1'b0);
        chk("supply_shutdown", 32'h1, {31'h0, supply_shutdown});
        supply_ov <= 1'b0;
        w(3);
        sw(1'b0, 1'b0);
        chk("supply_shutdown", 32'h1, {31'h0, supply_shutdown});
        wr(8'h50, 8'h11);
        wr(8'h40, 8'h10);
        supply_uv <= 1'b1;
        w(3);
        sw(1'b0, 1'b0);
        supply_uv <= 1'b0;
        w(3);
        sw(1'b1, 1'b1);
        wr(8'h40, 8'h60);
        supply_ov <= 1'b1;
        supply_uv <= 1'b1;
        w(3);
        sw(1'b1, 1'b1);
        chk("supply_shutdown", 32'h0, {31'h0, supply_shutdown});
        supply_ov <= 1'b0;
        supply_uv <= 1'b0;
        @(posedge mclk);
        sw_overcurrent <= 2'b01;
        @(posedge mclk);
        sw_overcurrent <= 2'b00;
        rd(8'h50, 8'h10);
        sw_overtemp <= 2'b10;
        @(posedge mclk);
        sw_overtemp <= 2'b00;
        rd(8'h50, 8'h00);
        $display("supply and fault test done");
    endtask : t_supply

    task automatic t_restart;
        wr(8'h40, 8'hff);
        wr(8'h34, 8'h11);
        wr(8'h50, 8'h11);
        @(posedge mclk);
        restart_entry <= 1'b1;
        @(posedge mclk);
        restart_entry <= 1'b0;
        rd(8'h34, 8'h00);
        rd(8'h50, 8'h00);
        rd(8'h40, 8'h70);
        restart_active <= 1'b1;
        cyclic_sense_active <= 1'b1;
        wr(8'h34, 8'h11);
        wr(8'h50, 8'h03);
        sw_overcurrent <= 2'b01;
        @(posedge mclk);
        sw_overcurrent <= 2'b00;
        rd(8'h34, 8'h00);
        restart_active <= 1'b0;
        soft_reset <= 1'b1;
        @(posedge mclk);
        soft_reset <= 1'b0;
        rd(8'h40, 8'h00);
        $display("restart test done");
    endtask : t_restart

    initial begin
        {mclk, nrst, soft_reset, restart_entry, restart_active} = 5'h00;
        {cyclic_sense_active, supply_ov, supply_uv, clr} = 4'h0;
        {pulse_gen_a, pulse_gen_b, avs_read, avs_write} = 4'h0;
        {sw_overcurrent, sw_overtemp} = 4'h0;
        avs_byteenable = 4'h1;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        num_errors = 0;
        checked = 0;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        t_regs();
        t_src();
        t_timer();
        t_supply();
        t_restart();
        end_sim();
    end
endmodule : sct_switch_timer_ctl_test

// File: verilog/sct_consts.svh
`ifndef SCT_CONSTS_SVH
`define SCT_CONSTS_SVH

// register indices; byte address is four times the index
`define SCT_IDX_TMR_A      8'h0c
`define SCT_IDX_TMR_B      8'h0d
`define SCT_IDX_SHUTDOWN   8'h10
`define SCT_IDX_SRC_A      8'h14
`define SCT_IDX_STATUS     8'h1f

// field positions
`define SCT_TMR_ON_LSB     4
`define SCT_TMR_PER_LSB    0
`define SCT_SD_OV_DIS_BIT  6
`define SCT_SD_UV_DIS_BIT  5
`define SCT_SD_REC_BIT     4
`define SCT_SRC_ONE_LSB    0
`define SCT_SRC_TWO_LSB    4

// reset values
`define SCT_RST_TMR        3'h0
`define SCT_RST_SD         3'h0
`define SCT_RST_SRC        3'h0

// timing: clock period, base tick and documented times
`define SCT_CLK_PERIOD_NS  4
`define SCT_TICK_NS        100000
`define SCT_TICK_CYCLES    (`SCT_TICK_NS / `SCT_CLK_PERIOD_NS)
`define SCT_TICK_US        100
`define SCT_ON_1_US        100
`define SCT_ON_2_US        300
`define SCT_ON_3_US        1000
`define SCT_ON_4_US        10000
`define SCT_ON_5_US        20000
`define SCT_PER_0_US       10000
`define SCT_PER_1_US       20000
`define SCT_PER_2_US       50000
`define SCT_PER_3_US       100000
`define SCT_PER_4_US       200000
`define SCT_PER_5_US       1000000
`define SCT_PER_6_US       2000000

`endif

// File: verilog/sct_cyclic_timer.sv
`timescale 1ns/1ps

module sct_cyclic_timer (
    input wire logic mclk,
    input wire logic nrst,
    sct_tmr_if.tmr   tif
);
    logic [15:0] cnt_r;
    logic [15:0] on_t;
    logic [15:0] per_t;
    logic        running;
    logic        out_r;

    // decode the codes into tick counts
    always_comb begin
        on_t    = sct_pkg::sct_on_ticks(tif.on_code);
        per_t   = sct_pkg::sct_per_ticks(tif.per_code);
        running = (on_t != 16'h0000) && (per_t != 16'h0000);
    end

    // period counter; a new setting restarts the period one cycle after the register takes it
    always_ff @(posedge mclk) begin
        if (!nrst || tif.load || !running) begin
            cnt_r <= 16'h0000;
        end else if (tif.tick) begin
            cnt_r <= (cnt_r >= per_t - 16'h0001) ? 16'h0000
                                                 : cnt_r + 16'h0001;
        end
    end

    // on at the head of each period, off for the rest
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            out_r <= 1'b0;
        end else if (tif.on_code == 3'(sct_pkg::SCT_ON_STOP_HIGH)) begin
            out_r <= 1'b1;
        end else begin
            out_r <= running && (cnt_r < on_t);
        end
    end

    assign tif.out = out_r;

endmodule : sct_cyclic_timer

// File: verilog/sct_pkg.sv
`include "sct_consts.svh"

package sct_pkg;

    // on-time codes of a cyclic timer
    typedef enum logic [2:0] {
        SCT_ON_STOP_LOW, SCT_ON_T1, SCT_ON_T2, SCT_ON_T3,
        SCT_ON_T4, SCT_ON_T5, SCT_ON_STOP_HIGH, SCT_ON_RSV
    } sct_on_code_t;

    // switch source codes
    typedef enum logic [2:0] {
        SCT_SRC_OFF, SCT_SRC_ON, SCT_SRC_TMR_A, SCT_SRC_TMR_B,
        SCT_SRC_PG_A, SCT_SRC_PG_B, SCT_SRC_RSV6, SCT_SRC_RSV7
    } sct_src_code_t;

    // on-time in base ticks, zero when not running
    function automatic logic [15:0] sct_on_ticks(input logic [2:0] code);
        unique case (code)
            3'h1:    sct_on_ticks = 16'(`SCT_ON_1_US / `SCT_TICK_US);
            3'h2:    sct_on_ticks = 16'(`SCT_ON_2_US / `SCT_TICK_US);
            3'h3:    sct_on_ticks = 16'(`SCT_ON_3_US / `SCT_TICK_US);
            3'h4:    sct_on_ticks = 16'(`SCT_ON_4_US / `SCT_TICK_US);
            3'h5:    sct_on_ticks = 16'(`SCT_ON_5_US / `SCT_TICK_US);
            default: sct_on_ticks = 16'h0000;
        endcase
    endfunction : sct_on_ticks

    // period in base ticks, zero for the reserved code
    function automatic logic [15:0] sct_per_ticks(input logic [2:0] code);
        unique case (code)
            3'h0:    sct_per_ticks = 16'(`SCT_PER_0_US / `SCT_TICK_US);
            3'h1:    sct_per_ticks = 16'(`SCT_PER_1_US / `SCT_TICK_US);
            3'h2:    sct_per_ticks = 16'(`SCT_PER_2_US / `SCT_TICK_US);
            3'h3:    sct_per_ticks = 16'(`SCT_PER_3_US / `SCT_TICK_US);
            3'h4:    sct_per_ticks = 16'(`SCT_PER_4_US / `SCT_TICK_US);
            3'h5:    sct_per_ticks = 16'(`SCT_PER_5_US / `SCT_TICK_US);
            3'h6:    sct_per_ticks = 16'(`SCT_PER_6_US / `SCT_TICK_US);
            default: sct_per_ticks = 16'h0000;
        endcase
    endfunction : sct_per_ticks

endpackage : sct_pkg

// File: verilog/sct_switch_timer_ctl.sv
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`include "sct_consts.svh"

module sct_switch_timer_ctl #(
    parameter int unsigned TICK_CYCLES = `SCT_TICK_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        soft_reset,
    input  wire logic        restart_entry,
    input  wire logic        restart_active,
    input  wire logic        cyclic_sense_active,
    input  wire logic        supply_ov,
    input  wire logic        supply_uv,
    input  wire logic [1:0]  sw_overcurrent,
    input  wire logic [1:0]  sw_overtemp,
    input  wire logic        pulse_gen_a,
    input  wire logic        pulse_gen_b,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             sw_one_on,
    output logic             sw_two_on,
    output logic             supply_shutdown,
    output logic             timer_a_out,
    output logic             timer_b_out
);

    // register state
    logic [2:0]  tmr_a_on_r;
    logic [2:0]  tmr_a_per_r;
    logic [2:0]  tmr_b_on_r;
    logic [2:0]  tmr_b_per_r;
    logic [2:0]  sd_ctrl_r;
    logic [2:0]  src_one_r;
    logic [2:0]  src_two_r;
    logic        held_off_r;
    logic        ack_r;
    logic [31:0] rdata_r;
    logic        sw_one_r;
    logic        sw_two_r;
    logic        load_a_r;
    logic        load_b_r;

    // decoded bus and event terms
    logic        bus_req;
    logic        wr_go;
    logic [5:0]  word_idx;
    logic        addr_ok;
    logic        wr_tmr_a;
    logic        wr_tmr_b;
    logic        wr_sd;
    logic        wr_src;
    logic [2:0]  wr_on;
    logic [2:0]  wr_per;
    logic [1:0]  sw_fault;
    logic        hw_clear_src;
    logic        clear_timers;
    logic        clear_all;
    logic        ov_sd;
    logic        uv_sd;
    logic        sd_now;
    logic        tick;
    logic [7:0]  rd_byte;

    sct_tmr_if tif_a ();
    sct_tmr_if tif_b ();

    // source selection for one switch
    function automatic logic sct_src_level(input logic [2:0] code,
                                           input logic       t_a,
                                           input logic       t_b,
                                           input logic       p_a,
                                           input logic       p_b);
        unique case (code)
            3'(sct_pkg::SCT_SRC_ON):    sct_src_level = 1'b1;
            3'(sct_pkg::SCT_SRC_TMR_A): sct_src_level = t_a;
            3'(sct_pkg::SCT_SRC_TMR_B): sct_src_level = t_b;
            3'(sct_pkg::SCT_SRC_PG_A):  sct_src_level = p_a;
            3'(sct_pkg::SCT_SRC_PG_B):  sct_src_level = p_b;
            default:                    sct_src_level = 1'b0;
        endcase
    endfunction : sct_src_level

    // an on-time write that starts a running timer
    function automatic logic sct_starts(input logic [2:0] code);
        sct_starts = (code != 3'(sct_pkg::SCT_ON_STOP_LOW))
                  && (code != 3'(sct_pkg::SCT_ON_STOP_HIGH))
                  && (code != 3'(sct_pkg::SCT_ON_RSV));
    endfunction : sct_starts

    // bus decode: one aligned word per register, low byte lane only
    always_comb begin
        bus_req  = avs_read || avs_write;
        wr_go    = avs_write && ack_r && avs_byteenable[0];
        word_idx = avs_address[7:2];
        addr_ok  = (avs_address[1:0] == 2'h0);
        wr_tmr_a = wr_go && addr_ok && (word_idx == 6'(`SCT_IDX_TMR_A));
        wr_tmr_b = wr_go && addr_ok && (word_idx == 6'(`SCT_IDX_TMR_B));
        wr_sd    = wr_go && addr_ok && (word_idx == 6'(`SCT_IDX_SHUTDOWN));
        wr_src   = wr_go && addr_ok && (word_idx == 6'(`SCT_IDX_SRC_A));
        wr_on    = avs_writedata[`SCT_TMR_ON_LSB +: 3];
        wr_per   = avs_writedata[`SCT_TMR_PER_LSB +: 3];
    end

    // reset and restart terms
    always_comb begin
        clear_all    = soft_reset;
        sw_fault     = sw_overcurrent | sw_overtemp;
        hw_clear_src = (sw_fault[0] && (src_one_r != 3'h0))
                    || (sw_fault[1] && (src_two_r != 3'h0));
        clear_timers = restart_active && cyclic_sense_active
                    && hw_clear_src;
    end

    // supply fault shutdown decision
    always_comb begin
        ov_sd  = supply_ov && !sd_ctrl_r[`SCT_SD_OV_DIS_BIT - 4];
        uv_sd  = supply_uv && !sd_ctrl_r[`SCT_SD_UV_DIS_BIT - 4];
        sd_now = ov_sd || uv_sd;
    end

    // bus handshake: one wait cycle, then the answer
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req && !ack_r;
        end
    end

    assign avs_waitrequest = bus_req && !ack_r;

    // first timer register, same encodings as the second
    always_ff @(posedge mclk) begin
        if (!nrst || clear_all) begin
            tmr_a_on_r  <= `SCT_RST_TMR;
            tmr_a_per_r <= `SCT_RST_TMR;
        end else if (restart_entry || clear_timers) begin
            tmr_a_on_r  <= `SCT_RST_TMR;
            tmr_a_per_r <= `SCT_RST_TMR;
        end else if (wr_tmr_a) begin
            tmr_a_on_r  <= wr_on;
            tmr_a_per_r <= wr_per;
        end
    end

    // second timer register
    always_ff @(posedge mclk) begin
        if (!nrst || clear_all) begin
            tmr_b_on_r  <= `SCT_RST_TMR;
            tmr_b_per_r <= `SCT_RST_TMR;
        end else if (restart_entry || clear_timers) begin
            tmr_b_on_r  <= `SCT_RST_TMR;
            tmr_b_per_r <= `SCT_RST_TMR;
        end else if (wr_tmr_b) begin
            tmr_b_on_r  <= wr_on;
            tmr_b_per_r <= wr_per;
        end
    end

    // timer restart pulses: a running on-time write begins a new period
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            load_a_r <= 1'b0;
            load_b_r <= 1'b0;
        end else begin
            load_a_r <= wr_tmr_a && sct_starts(wr_on);
            load_b_r <= wr_tmr_b && sct_starts(wr_on);
        end
    end

    // shutdown control; restart entry leaves bits 6:4 alone
    always_ff @(posedge mclk) begin
        if (!nrst || clear_all) begin
            sd_ctrl_r <= `SCT_RST_SD;
        end else if (wr_sd) begin
            sd_ctrl_r <= avs_writedata[6:4];
        end
    end

    // switch one source; a switch fault wins over a write
    always_ff @(posedge mclk) begin
        if (!nrst || clear_all) begin
            src_one_r <= `SCT_RST_SRC;
        end else if (restart_entry) begin
            src_one_r <= `SCT_RST_SRC;
        end else if (sw_fault[0]) begin
            src_one_r <= 3'(sct_pkg::SCT_SRC_OFF);
        end else if (wr_src) begin
            src_one_r <= avs_writedata[`SCT_SRC_ONE_LSB +: 3];
        end
    end

    // switch two source
    always_ff @(posedge mclk) begin
        if (!nrst || clear_all) begin
            src_two_r <= `SCT_RST_SRC;
        end else if (restart_entry) begin
            src_two_r <= `SCT_RST_SRC;
        end else if (sw_fault[1]) begin
            src_two_r <= 3'(sct_pkg::SCT_SRC_OFF);
        end else if (wr_src) begin
            src_two_r <= avs_writedata[`SCT_SRC_TWO_LSB +: 3];
        end
    end

    // latched shutdown: released when the fault ends with recovery on,
    // otherwise only by a new source write or a soft reset
    always_ff @(posedge mclk) begin
        if (!nrst || clear_all) begin
            held_off_r <= 1'b0;
        end else if (sd_now) begin
            held_off_r <= 1'b1;
        end else if (sd_ctrl_r[`SCT_SD_REC_BIT - 4] || wr_src) begin
            held_off_r <= 1'b0;
        end
    end

    // base tick for both timers
    sct_tick_div #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .mclk    (mclk),
        .nrst    (nrst),
        .restart (clear_all),
        .tick    (tick)
    );

    // timer settings onto the carriers
    assign tif_a.tick     = tick;
    assign tif_a.load     = load_a_r;
    assign tif_a.on_code  = tmr_a_on_r;
    assign tif_a.per_code = tmr_a_per_r;
    assign tif_b.tick     = tick;
    assign tif_b.load     = load_b_r;
    assign tif_b.on_code  = tmr_b_on_r;
    assign tif_b.per_code = tmr_b_per_r;

    // first cyclic timer
    sct_cyclic_timer u_tmr_a (
        .mclk (mclk),
        .nrst (nrst),
        .tif  (tif_a)
    );

    // second cyclic timer
    sct_cyclic_timer u_tmr_b (
        .mclk (mclk),
        .nrst (nrst),
        .tif  (tif_b)
    );

    // switch outputs: source mux gated by supply shutdown
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sw_one_r <= 1'b0;
            sw_two_r <= 1'b0;
        end else if (sd_now || held_off_r) begin
            sw_one_r <= 1'b0;
            sw_two_r <= 1'b0;
        end else begin
            sw_one_r <= sct_src_level(src_one_r, tif_a.out, tif_b.out,
                                      pulse_gen_a, pulse_gen_b);
            sw_two_r <= sct_src_level(src_two_r, tif_a.out, tif_b.out,
                                      pulse_gen_a, pulse_gen_b);
        end
    end

    assign sw_one_on       = sw_one_r;
    assign sw_two_on       = sw_two_r;
    assign supply_shutdown = sd_now || held_off_r;
    assign timer_a_out     = tif_a.out;
    assign timer_b_out     = tif_b.out;

    // read mux; reserved bits and unmapped words read zero
    always_comb begin
        rd_byte = 8'h00;
        if (addr_ok) begin
            unique case (word_idx)
                6'(`SCT_IDX_TMR_A):    rd_byte = {1'b0, tmr_a_on_r,
                                                  1'b0, tmr_a_per_r};
                6'(`SCT_IDX_TMR_B):    rd_byte = {1'b0, tmr_b_on_r,
                                                  1'b0, tmr_b_per_r};
                6'(`SCT_IDX_SHUTDOWN): rd_byte = {1'b0, sd_ctrl_r,
                                                  4'h0};
                6'(`SCT_IDX_SRC_A):    rd_byte = {1'b0, src_two_r,
                                                  1'b0, src_one_r};
                6'(`SCT_IDX_STATUS):   rd_byte = {2'h0, held_off_r,
                                                  sd_now, sw_two_r,
                                                  sw_one_r, tif_b.out,
                                                  tif_a.out};
                default:               rd_byte = 8'h00;
            endcase
        end
    end

    // read data captured in the wait cycle, held until the next read
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            rdata_r <= {24'h00_0000, rd_byte};
        end
    end

    assign avs_readdata = rdata_r;

endmodule : sct_switch_timer_ctl

// File: verilog/sct_tick_div.sv
`timescale 1ns/1ps

module sct_tick_div #(
    parameter int unsigned CYCLES = 25000
) (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic restart,
    output logic      tick
);
    localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_r;
    logic         tick_r;

    // free-running divider, one-cycle tick at wrap
    always_ff @(posedge mclk) begin
        if (!nrst || restart) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (cnt_r == LAST);
            cnt_r  <= (cnt_r == LAST) ? '0 : cnt_r + W'(1);
        end
    end

    assign tick = tick_r;

endmodule : sct_tick_div

// File: verilog/sct_tmr_if.sv
`timescale 1ns/1ps

// carries one timer's settings in and its output back
interface sct_tmr_if;
    logic       tick;
    logic       load;
    logic [2:0] on_code;
    logic [2:0] per_code;
    logic       out;
    modport ctl (output tick, output load, output on_code,
                 output per_code, input out);
    modport tmr (input tick, input load, input on_code,
                 input per_code, output out);
endinterface : sct_tmr_if
